//--- pll_cfg_pkg.sv
// constants, codes and carrier types for the loop configuration bank
package pll_cfg_pkg;

   // register offsets on the serial configuration link
   localparam logic [7:0] OFS_SPREAD_HI  = 8'h10;
   localparam logic [7:0] OFS_SPREAD_MID = 8'h11;
   localparam logic [7:0] OFS_SPREAD_LO  = 8'h12;
   localparam logic [7:0] OFS_VCO_SEL    = 8'h13;
   localparam logic [7:0] OFS_MUX_DEFS   = 8'h14;
   localparam logic [7:0] OFS_OUT_SEL    = 8'h15;
   localparam logic [7:0] OFS_DIR_POST_DIVIDER_TWO  = 8'h16;
   localparam logic [7:0] OFS_POST_DIVIDER_THREE      = 8'h17;
   localparam logic [7:0] OFS_POST_DIVIDER_ONE      = 8'h20;

   // field positions
   localparam int BYPASS_BIT   = 7;
   localparam int SRC2_BIT     = 6;
   localparam int SRC3_LSB     = 4;
   localparam int DEF_ONE_LSB  = 2;
   localparam int DEF_ZERO_LSB = 0;
   localparam int DIR_BIT      = 7;
   localparam int SPREAD_W     = 3;

   // reset values
   localparam logic [7:0] RST_SPREAD  = 8'h00;
   localparam logic [7:0] RST_VCO_SEL = 8'h00;
   localparam logic [7:0] RST_MUX     = 8'hED;
   localparam logic [7:0] RST_OUT_SEL = 8'h02;
   localparam logic       RST_DIR     = 1'b0;
   localparam logic [6:0] RST_PDIV    = 7'h01;

   // output pair state codes
   localparam logic [1:0] OUT_OFF_PD = 2'h0;
   localparam logic [1:0] OUT_HIZ    = 2'h1;
   localparam logic [1:0] OUT_LOW    = 2'h2;
   localparam logic [1:0] OUT_ON     = 2'h3;

   // third output source codes
   localparam logic [1:0] SRC3_DIV1 = 2'h0;
   localparam logic [1:0] SRC3_DIV2 = 2'h1;
   localparam logic [1:0] SRC3_DIV3 = 2'h2;

   // spread depth per code, in hundredths of a percent
   localparam logic [7:0] SPREAD_DEPTH [8] = '{8'h00, 8'h19, 8'h32, 8'h4B, 8'h64, 8'h7D, 8'h96, 8'hC8};

   // link slave address; value is arbitrary
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h5A;

   typedef struct packed {
      logic [2:0] spread;
      logic       vco_sel;
      logic       def_sel;
   } state_sel_t;

   typedef struct packed {
      logic scl;
      logic sda;
      logic [2:0] pins;
   } pin_in_t;

   typedef enum {
      L_IDLE,
      L_ADDR,
      L_ADDR_ACK,
      L_OFS,
      L_OFS_ACK,
      L_WDATA,
      L_WDATA_ACK,
      L_RDATA,
      L_RDATA_ACK
   } link_state_t;

endpackage : pll_cfg_pkg

//--- sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         core_clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_r <= '0;
         q_r    <= '0;
      end
      else
      begin
         meta_r <= d;
         q_r    <= meta_r;
      end
   end

   assign q = q_r;
endmodule : sync2

//--- pll_ssc_output_state_config.sv
// loop configuration bank: serial register slave, per-state selection, post-dividers and output pair control
//
// Notes on behaviour
// R1: down-spread codes 000..111 mean off, 0.25 to 1.5 in quarter steps, then 2.0 percent.
// R2: center-spread uses the same codes as symmetric plus/minus spreads.
// R3: direction bit 7 of offset 16h: 0 down, 1 center; resets to 0.
// R4: eight per-state settings, picked by the three control pins.
// R5: frequency-select bit of active state picks loop setting zero or one.
// R6: bypass bit 0 routes loop to dividers; 1 bypasses and powers loop down; reset 1.
// R7: second output from divider one when source bit 0, divider two when 1; reset 1.
// R8: third output source codes 00,01,10 pick dividers one to three; reset 10; 11 reserved.
// R9: output definition codes: 00 off with loop down, 01 off, 10 low, 11 on.
// R10: state select bit picks definition zero or one; after reset only state one picks one.
// R11: host must not write offsets above 20h.
// R12: every register byte moves across the link most significant bit first.
// R13: post-dividers divide by 1 to 127; value 0 holds the divider in reset.
// R14: selection follows fields on the following clock, and pins three clocks after they change.
`timescale 1ns/1ps
module pll_ssc_output_state_config
   import pll_cfg_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic       state_pin_zero,
   input  wire logic       state_pin_one,
   input  wire logic       state_pin_two,
   output logic [2:0]      spread_amount_field,
   output logic [7:0]      spread_depth,
   output logic            spread_direction_bit,
   output logic            vco_setting_select_bit,
   output logic            loop_bypass_select,
   output logic            loop_power_down,
   output logic            second_output_source_select,
   output logic [1:0]      third_output_source_select,
   output logic [1:0]      out_pair_state,
   output logic            second_clock_output,
   output logic            second_clock_output_oe,
   output logic            third_clock_output,
   output logic            third_clock_output_oe
);

   pin_in_t     pin_raw;
   pin_in_t     pin_s;
   logic        scl_d_r;
   logic        sda_d_r;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_seen;
   logic        stop_seen;

   assign pin_raw = '{scl: scl_in, sda: sda_in, pins: {state_pin_two, state_pin_one, state_pin_zero}};

   sync2 #(.W(5)) u_sync (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .d        (pin_raw),
      .q        (pin_s)
   );

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end
      else
      begin
         scl_d_r <= pin_s.scl;
         sda_d_r <= pin_s.sda;
      end
   end

   assign scl_rise   = pin_s.scl & ~scl_d_r;
   assign scl_fall   = ~pin_s.scl & scl_d_r;
   assign start_seen = pin_s.scl & scl_d_r & sda_d_r & ~pin_s.sda;
   assign stop_seen  = pin_s.scl & scl_d_r & ~sda_d_r & pin_s.sda;

   // register storage
   logic [23:0] spread_r,  spread_nxt;
   logic [7:0]  vco_sel_r, vco_sel_nxt;
   logic [7:0]  mux_r,     mux_nxt;
   logic [7:0]  out_sel_r, out_sel_nxt;
   logic        dir_r,     dir_nxt;
   logic [6:0]  post_divider_one_r,   post_divider_one_nxt;
   logic [6:0]  post_divider_two_r,   post_divider_two_nxt;
   logic [6:0]  post_divider_three_r,   post_divider_three_nxt;

   // link slave state
   link_state_t st_r,    st_nxt;
   logic [3:0]  bit_r,   bit_nxt;
   logic [7:0]  shift_r, shift_nxt;
   logic [7:0]  ptr_r,   ptr_nxt;
   logic        rw_r,    rw_nxt;
   logic        oe_r,    oe_nxt;
   logic        wr_en;
   logic [7:0]  rd_data;

   always_comb
   begin
      unique case (ptr_r)
         OFS_SPREAD_HI:  rd_data = spread_r[23:16];
         OFS_SPREAD_MID: rd_data = spread_r[15:8];
         OFS_SPREAD_LO:  rd_data = spread_r[7:0];
         OFS_VCO_SEL:    rd_data = vco_sel_r;
         OFS_MUX_DEFS:   rd_data = mux_r;
         OFS_OUT_SEL:    rd_data = out_sel_r;
         OFS_DIR_POST_DIVIDER_TWO:  rd_data = {dir_r, post_divider_two_r};
         OFS_POST_DIVIDER_THREE:      rd_data = {1'b0, post_divider_three_r};
         OFS_POST_DIVIDER_ONE:      rd_data = {1'b0, post_divider_one_r};
         default:        rd_data = 8'h00;
      endcase
   end

   always_comb
   begin
      st_nxt    = st_r;
      bit_nxt   = bit_r;
      shift_nxt = shift_r;
      ptr_nxt   = ptr_r;
      rw_nxt    = rw_r;
      oe_nxt    = oe_r;
      wr_en     = 1'b0;
      if (start_seen)
      begin
         st_nxt  = L_ADDR;
         // the start's own clock fall wraps this to zero, so it is not counted as a bit
         bit_nxt = 4'hF;
         oe_nxt  = 1'b0;
      end
      else if (stop_seen)
      begin
         st_nxt = L_IDLE;
         oe_nxt = 1'b0;
      end
      else
      begin
         unique case (st_r)
            L_IDLE:
            begin
               oe_nxt = 1'b0;
            end
            L_ADDR, L_OFS, L_WDATA:
            begin
               if (scl_rise)
                  shift_nxt = {shift_r[6:0], pin_s.sda}; // R12
               else if (scl_fall)
               begin
                  if (bit_r == 4'h7)
                  begin
                     bit_nxt = 4'h0;
                     oe_nxt  = 1'b1;
                     if (st_r == L_ADDR)
                     begin
                        if (shift_r[7:1] == DEV_ADDR)
                        begin
                           st_nxt = L_ADDR_ACK;
                           rw_nxt = shift_r[0];
                        end
                        else
                        begin
                           st_nxt = L_IDLE;
                           oe_nxt = 1'b0;
                        end
                     end
                     else if (st_r == L_OFS)
                     begin
                        st_nxt  = L_OFS_ACK;
                        ptr_nxt = shift_r;
                     end
                     else
                     begin
                        st_nxt  = L_WDATA_ACK;
                        wr_en   = 1'b1;
                        ptr_nxt = ptr_r + 8'h01;
                     end
                  end
                  else
                     bit_nxt = bit_r + 4'h1;
               end
            end
            L_ADDR_ACK, L_OFS_ACK, L_WDATA_ACK:
            begin
               if (scl_fall)
               begin
                  oe_nxt = 1'b0;
                  if (st_r == L_ADDR_ACK && rw_r)
                  begin
                     st_nxt    = L_RDATA;
                     shift_nxt = rd_data;
                     ptr_nxt   = ptr_r + 8'h01;
                     oe_nxt    = ~rd_data[7]; // R12
                  end
                  else if (st_r == L_ADDR_ACK)
                     st_nxt = L_OFS;
                  else
                     st_nxt = L_WDATA;
               end
            end
            L_RDATA:
            begin
               if (scl_fall)
               begin
                  if (bit_r == 4'h7)
                  begin
                     st_nxt  = L_RDATA_ACK;
                     bit_nxt = 4'h0;
                     oe_nxt  = 1'b0;
                  end
                  else
                  begin
                     bit_nxt   = bit_r + 4'h1;
                     shift_nxt = {shift_r[6:0], 1'b0};
                     oe_nxt    = ~shift_r[6]; // R12
                  end
               end
            end
            L_RDATA_ACK:
            begin
               if (scl_rise && pin_s.sda)
                  st_nxt = L_IDLE;
               else if (scl_fall)
               begin
                  st_nxt    = L_RDATA;
                  shift_nxt = rd_data;
                  ptr_nxt   = ptr_r + 8'h01;
                  oe_nxt    = ~rd_data[7];
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_r    <= L_IDLE;
         bit_r   <= 4'h0;
         shift_r <= 8'h00;
         ptr_r   <= 8'h00;
         rw_r    <= 1'b0;
         oe_r    <= 1'b0;
      end
      else
      begin
         st_r    <= st_nxt;
         bit_r   <= bit_nxt;
         shift_r <= shift_nxt;
         ptr_r   <= ptr_nxt;
         rw_r    <= rw_nxt;
         oe_r    <= oe_nxt;
      end
   end

   // writes to unmapped offsets are acknowledged and dropped
   always_comb
   begin
      spread_nxt  = spread_r;
      vco_sel_nxt = vco_sel_r;
      mux_nxt     = mux_r;
      out_sel_nxt = out_sel_r;
      dir_nxt     = dir_r;
      post_divider_one_nxt   = post_divider_one_r;
      post_divider_two_nxt   = post_divider_two_r;
      post_divider_three_nxt   = post_divider_three_r;
      if (wr_en)
      begin
         unique case (ptr_r)
            OFS_SPREAD_HI:  spread_nxt[23:16] = shift_r;
            OFS_SPREAD_MID: spread_nxt[15:8]  = shift_r;
            OFS_SPREAD_LO:  spread_nxt[7:0]   = shift_r;
            OFS_VCO_SEL:    vco_sel_nxt       = shift_r;
            OFS_MUX_DEFS:   mux_nxt           = shift_r;
            OFS_OUT_SEL:    out_sel_nxt       = shift_r;
            OFS_DIR_POST_DIVIDER_TWO:
            begin
               dir_nxt   = shift_r[DIR_BIT];
               post_divider_two_nxt = shift_r[6:0];
            end
            OFS_POST_DIVIDER_THREE:      post_divider_three_nxt = shift_r[6:0];
            OFS_POST_DIVIDER_ONE:      post_divider_one_nxt = shift_r[6:0];
            default:        spread_nxt = spread_r;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         spread_r  <= {RST_SPREAD, RST_SPREAD, RST_SPREAD};
         vco_sel_r <= RST_VCO_SEL;
         mux_r     <= RST_MUX; // R6 R7 R8 R9
         out_sel_r <= RST_OUT_SEL; // R10
         dir_r     <= RST_DIR; // R3
         post_divider_one_r   <= RST_PDIV;
         post_divider_two_r   <= RST_PDIV;
         post_divider_three_r   <= RST_PDIV;
      end
      else
      begin
         spread_r  <= spread_nxt;
         vco_sel_r <= vco_sel_nxt;
         mux_r     <= mux_nxt;
         out_sel_r <= out_sel_nxt;
         dir_r     <= dir_nxt;
         post_divider_one_r   <= post_divider_one_nxt;
         post_divider_two_r   <= post_divider_two_nxt;
         post_divider_three_r   <= post_divider_three_nxt;
      end
   end

   // post-dividers run on core_clk here, standing in for the loop clock
   logic [6:0] div_val [3];
   logic [2:0] div_tick;

   assign div_val[0] = post_divider_one_r;
   assign div_val[1] = post_divider_two_r;
   assign div_val[2] = post_divider_three_r;

   for (genvar i = 0; i < 3; i++)
   begin : g_div
      logic [6:0] cnt_r, cnt_nxt;
      logic       tick_r, tick_nxt;
      always_comb
      begin
         cnt_nxt  = cnt_r + 7'h01;
         tick_nxt = 1'b0;
         if (div_val[i] == 7'h00)
            cnt_nxt = 7'h00; // R13
         else if (cnt_r >= div_val[i] - 7'h01)
         begin
            cnt_nxt  = 7'h00; // R13
            tick_nxt = 1'b1;
         end
      end
      always_ff @(posedge core_clk or negedge arst_n)
      begin
         if (!arst_n)
         begin
            cnt_r  <= 7'h00;
            tick_r <= 1'b0;
         end
         else
         begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
         end
      end
      assign div_tick[i] = tick_r;
   end

   // active state selection, one register stage after the synchronised pins
   state_sel_t sel;
   logic [1:0] def_act;
   logic       src2_tick;
   logic       src3_tick;
   logic [2:0] amt_nxt;
   logic       y2_nxt, y2_oe_nxt, y3_nxt, y3_oe_nxt;

   always_comb
   begin
      sel.spread  = spread_r[SPREAD_W*pin_s.pins +: SPREAD_W]; // R4 R14
      sel.vco_sel = vco_sel_r[pin_s.pins]; // R4 R5
      sel.def_sel = out_sel_r[pin_s.pins]; // R4 R10
      def_act     = sel.def_sel ? mux_r[DEF_ONE_LSB +: 2] : mux_r[DEF_ZERO_LSB +: 2]; // R10
      src2_tick   = mux_r[SRC2_BIT] ? div_tick[1] : div_tick[0]; // R7
      unique case (mux_r[SRC3_LSB +: 2])
         SRC3_DIV1: src3_tick = div_tick[0]; // R8
         SRC3_DIV2: src3_tick = div_tick[1]; // R8
         SRC3_DIV3: src3_tick = div_tick[2]; // R8
         default:   src3_tick = 1'b0;
      endcase
      // R9: 0x codes release the pins, 10 drives low, 11 passes the clock
      y2_oe_nxt = def_act[1];
      y3_oe_nxt = def_act[1];
      y2_nxt    = (def_act == OUT_ON) & src2_tick;
      y3_nxt    = (def_act == OUT_ON) & src3_tick;
      amt_nxt   = sel.spread;
   end

   logic [2:0] amt_r;
   logic [7:0] depth_r;
   logic       dir_o_r, vco_r, byp_r, pd_r, src2_r;
   logic [1:0] src3_r, def_r;
   logic       y2_r, y2_oe_r, y3_r, y3_oe_r;

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         amt_r   <= 3'h0;
         depth_r <= 8'h00;
         dir_o_r <= RST_DIR;
         vco_r   <= 1'b0;
         byp_r   <= RST_MUX[BYPASS_BIT];
         pd_r    <= RST_MUX[BYPASS_BIT];
         src2_r  <= RST_MUX[SRC2_BIT];
         src3_r  <= RST_MUX[SRC3_LSB +: 2];
         def_r   <= RST_MUX[DEF_ZERO_LSB +: 2];
         y2_r    <= 1'b0;
         y2_oe_r <= 1'b0;
         y3_r    <= 1'b0;
         y3_oe_r <= 1'b0;
      end
      else
      begin
         amt_r   <= amt_nxt; // R14
         depth_r <= SPREAD_DEPTH[amt_nxt]; // R1 R2
         dir_o_r <= dir_r; // R3
         vco_r   <= sel.vco_sel; // R5
         byp_r   <= mux_r[BYPASS_BIT]; // R6
         pd_r    <= mux_r[BYPASS_BIT] | (def_act == OUT_OFF_PD); // R6 R9
         src2_r  <= mux_r[SRC2_BIT];
         src3_r  <= mux_r[SRC3_LSB +: 2];
         def_r   <= def_act;
         y2_r    <= y2_nxt;
         y2_oe_r <= y2_oe_nxt;
         y3_r    <= y3_nxt;
         y3_oe_r <= y3_oe_nxt;
      end
   end

   // open-drain: the pin is only ever pulled low
   logic sda_lo_r;
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         sda_lo_r <= 1'b0;
      else
         sda_lo_r <= 1'b0;
   end

   assign sda_out                     = sda_lo_r;
   assign sda_oe                      = oe_r;
   assign spread_amount_field         = amt_r;
   assign spread_depth                = depth_r;
   assign spread_direction_bit        = dir_o_r;
   assign vco_setting_select_bit      = vco_r;
   assign loop_bypass_select          = byp_r;
   assign loop_power_down             = pd_r;
   assign second_output_source_select = src2_r;
   assign third_output_source_select  = src3_r;
   assign out_pair_state              = def_r;
   assign second_clock_output         = y2_r;
   assign second_clock_output_oe      = y2_oe_r;
   assign third_clock_output          = y3_r;
   assign third_clock_output_oe       = y3_oe_r;

endmodule : pll_ssc_output_state_config

//--- pll_cfg_chk.sv
// concurrent checks on the loop configuration bank ports
`timescale 1ns/1ps
module pll_cfg_chk
   import pll_cfg_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       arst_n,
   input wire logic       scl_in,
   input wire logic       sda_oe,
   input wire logic [2:0] spread_amount_field,
   input wire logic [7:0] spread_depth,
   input wire logic       spread_direction_bit,
   input wire logic       loop_bypass_select,
   input wire logic       loop_power_down,
   input wire logic       second_output_source_select,
   input wire logic [1:0] third_output_source_select,
   input wire logic [1:0] out_pair_state,
   input wire logic       second_clock_output,
   input wire logic       second_clock_output_oe,
   input wire logic       third_clock_output,
   input wire logic       third_clock_output_oe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_power_down_eq: assert property (loop_power_down == (loop_bypass_select || out_pair_state == OUT_OFF_PD))
      else $error("power down mismatch");
   a_depth_decode: assert property (spread_depth == SPREAD_DEPTH[spread_amount_field])
      else $error("spread depth mismatch");
   a_enable_level: assert property (second_clock_output_oe == out_pair_state[1] && third_clock_output_oe == out_pair_state[1])
      else $error("output enable mismatch");
   a_quiet_unless_on: assert property (out_pair_state != OUT_ON |-> !second_clock_output && !third_clock_output)
      else $error("output active while not enabled");
   a_src3_reserved: assert property (third_output_source_select == 2'h3 |-> !third_clock_output)
      else $error("reserved source drives output");
   a_reset_muxes: assert property ($rose(arst_n) |-> loop_bypass_select && second_output_source_select && third_output_source_select == SRC3_DIV3)
      else $error("mux reset value wrong");
   a_reset_state: assert property ($rose(arst_n) |-> out_pair_state == OUT_HIZ && !spread_direction_bit && spread_depth == 8'h00)
      else $error("state reset value wrong");
   // the device moves data only while the link clock is low, so it never forges a start or stop
   a_link_change_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data changed with clock high");

   cover property (out_pair_state == OUT_ON && second_clock_output);
   cover property (spread_direction_bit && spread_depth == 8'hC8);
   cover property ($rose(sda_oe));
endmodule : pll_cfg_chk

bind pll_ssc_output_state_config pll_cfg_chk u_chk (.*);

//--- cfg_host.sv
// two-wire host model that programs the bank over an open-drain data line
`timescale 1ns/1ps
module cfg_host
   import pll_cfg_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic sda_oe,
   output logic      scl,
   output logic      sda
);
   logic pull_low;

   // pull-up: the line reads high whenever nobody pulls it
   assign sda = !(pull_low || sda_oe);

   initial
   begin
      scl = 1'b1;
      pull_low = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : wait_clk

   // data changes only with the clock low, two cycles after the fall, once the synchronisers see it
   task automatic put_bit(input logic b);
      pull_low = !b;
      wait_clk(6);
      scl = 1'b1;
      wait_clk(6);
      scl = 1'b0;
      wait_clk(2);
   endtask : put_bit

   task automatic get_bit(output logic b);
      pull_low = 1'b0;
      wait_clk(6);
      scl = 1'b1;
      wait_clk(5);
      b = sda;
      wait_clk(1);
      scl = 1'b0;
      wait_clk(2);
   endtask : get_bit

   task automatic start_cond();
      wait_clk(6);
      pull_low = 1'b1;
      wait_clk(6);
      scl = 1'b0;
      wait_clk(2);
   endtask : start_cond

   task automatic stop_cond();
      pull_low = 1'b1;
      wait_clk(6);
      scl = 1'b1;
      wait_clk(6);
      pull_low = 1'b0;
      wait_clk(6);
   endtask : stop_cond

   task automatic send_byte(input logic [7:0] v, output logic nack);
      for (int i = 7; i >= 0; i--)
         put_bit(v[i]);
      get_bit(nack);
   endtask : send_byte

   task automatic write_reg(input logic [6:0] adr, input logic [7:0] ofs, input logic [7:0] dat, output logic nack);
      logic n0, n1, n2;
      nack = 1'b1;
      if (ofs > OFS_POST_DIVIDER_ONE)
         return;
      start_cond();
      send_byte({adr, 1'b0}, n0);
      send_byte(ofs, n1);
      send_byte(dat, n2);
      stop_cond();
      nack = n0 | n1 | n2;
   endtask : write_reg

   task automatic read_reg(input logic [7:0] ofs, output logic [7:0] v);
      logic n;
      start_cond();
      send_byte({DEV_ADDR_DEFAULT, 1'b0}, n);
      send_byte(ofs, n);
      stop_cond();
      start_cond();
      send_byte({DEV_ADDR_DEFAULT, 1'b1}, n);
      for (int i = 7; i >= 0; i--)
         get_bit(v[i]);
      put_bit(1'b1);
      stop_cond();
   endtask : read_reg
endmodule : cfg_host

//--- testbench.sv
// self-checking bench for the loop configuration bank
`timescale 1ns/1ps
module testbench
   import pll_cfg_pkg::*;
;
   typedef struct packed {
      logic [2:0] pins;
      logic [7:0] depth;
      logic       vco;
      logic [1:0] ost;
   } row_t;
   // state k holds spread code k; vco bits A5h, odd states pick definition one
   localparam row_t ROWS [8] = '{'{3'h0, 8'h00, 1'b1, 2'h2}, '{3'h1, 8'h19, 1'b0, 2'h3}, '{3'h2, 8'h32, 1'b1, 2'h2},
                                 '{3'h3, 8'h4B, 1'b0, 2'h3}, '{3'h4, 8'h64, 1'b0, 2'h2}, '{3'h5, 8'h7D, 1'b1, 2'h3},
                                 '{3'h6, 8'h96, 1'b0, 2'h2}, '{3'h7, 8'hC8, 1'b1, 2'h3}};
   logic       core_clk, arst_n, scl_in, sda_in, sda_out, sda_oe, nack;
   logic       state_pin_zero, state_pin_one, state_pin_two;
   logic [2:0] spread_amount_field;
   logic [7:0] spread_depth;
   logic       spread_direction_bit, vco_setting_select_bit, loop_bypass_select, loop_power_down;
   logic       second_output_source_select, second_clock_output, second_clock_output_oe;
   logic       third_clock_output, third_clock_output_oe;
   logic [1:0] third_output_source_select, out_pair_state, c;
   int         errors, checks_done, cycles, n_two, n_three;

   pll_ssc_output_state_config u_dut (.*);
   cfg_host u_host (.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl_in), .sda(sda_in));

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic results;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] ofs, input logic [7:0] dat);
      u_host.write_reg(DEV_ADDR_DEFAULT, ofs, dat, nack);
      check(nack, 1'b0);
   endtask : wr

   task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
      logic [7:0] v;
      u_host.read_reg(ofs, v);
      check(v, exp);
   endtask : rd

   // pins pass two synchroniser flops and a register, so five cycles leave margin
   task automatic settle(input logic [2:0] k);
      {state_pin_two, state_pin_one, state_pin_zero} = k;
      repeat (5) @(posedge core_clk);
      #1;
   endtask : settle

   task automatic count_ticks;
      n_two = 0;
      n_three = 0;
      repeat (20)
      begin
         @(posedge core_clk);
         #1;
         n_two += int'(second_clock_output === 1'b1);
         n_three += int'(third_clock_output === 1'b1);
      end
   endtask : count_ticks

   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         errors++;
         results;
      end
   end

   initial
   begin
      arst_n = 1'b0;
      {state_pin_two, state_pin_one, state_pin_zero} = 3'h0;
      repeat (2) @(posedge core_clk);
      #1;
      check(loop_bypass_select, 1'b1);
      check(second_output_source_select, 1'b1);
      check(third_output_source_select, 2'h2);
      check(out_pair_state, 2'h1);
      check(sda_out, 1'b0);
      arst_n = 1'b1;
      settle(3'h1);
      check(out_pair_state, 2'h3);
      check(second_clock_output_oe, 1'b1);
      check(second_clock_output, 1'b1);
      check(loop_power_down, 1'b1);
      rd(OFS_MUX_DEFS, 8'hED);
      rd(OFS_OUT_SEL, 8'h02);
      rd(OFS_DIR_POST_DIVIDER_TWO, 8'h01);
      $display("test reset done");
      wr(OFS_SPREAD_HI, 8'hFA);
      wr(OFS_SPREAD_MID, 8'hC6);
      wr(OFS_SPREAD_LO, 8'h88);
      wr(OFS_VCO_SEL, 8'hA5);
      wr(OFS_MUX_DEFS, 8'h1E);
      wr(OFS_OUT_SEL, 8'hAA);
      rd(OFS_SPREAD_MID, 8'hC6);
      foreach (ROWS[i])
      begin
         settle(ROWS[i].pins);
         check(spread_amount_field, ROWS[i].pins);
         check(spread_depth, ROWS[i].depth);
         check(vco_setting_select_bit, ROWS[i].vco);
         check(out_pair_state, ROWS[i].ost);
         check(second_clock_output_oe, 1'b1);
         check(second_clock_output, ROWS[i].ost[0]);
         check(third_clock_output, ROWS[i].ost[0]);
         check(loop_power_down, 1'b0);
      end
      $display("test state table done");
      wr(OFS_DIR_POST_DIVIDER_TWO, 8'h82);
      wr(OFS_MUX_DEFS, 8'h5E);
      check(spread_direction_bit, 1'b1);
      check(spread_depth, 8'hC8);
      count_ticks;
      check(n_two[7:0], 8'h0A);
      check(n_three[7:0], 8'h0A);
      wr(OFS_POST_DIVIDER_THREE, 8'h00);
      wr(OFS_MUX_DEFS, 8'h6E);
      count_ticks;
      check(n_three[7:0], 8'h00);
      $display("test spread and dividers done");
      for (int k = 0; k < 4; k++)
      begin
         c = k[1:0];
         // source code 11 is reserved, so software substitutes 10 there
         wr(OFS_MUX_DEFS, {c[0], c[1], (c == 2'h3) ? 2'h2 : c, 2'h3, c});
         settle(3'h0);
         check(out_pair_state, c);
         check(third_clock_output_oe, c[1]);
         check(loop_power_down, c[0] || c == 2'h0);
         check(loop_bypass_select, c[0]);
         check(second_output_source_select, c[1]);
         check(third_output_source_select, (c == 2'h3) ? 2'h2 : c);
      end
      $display("test output states done");
      rd(8'h18, 8'h00);
      u_host.write_reg(DEV_ADDR_DEFAULT ^ 7'h01, OFS_OUT_SEL, 8'h00, nack);
      check(nack, 1'b1);
      rd(OFS_OUT_SEL, 8'hAA);
      $display("test refusals done");
      arst_n = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      arst_n = 1'b1;
      settle(3'h0);
      check(spread_direction_bit, 1'b0);
      check(out_pair_state, 2'h1);
      rd(OFS_SPREAD_HI, 8'h00);
      $display("test second reset done");
      results;
   end
endmodule : testbench
